// ### src/irq_ctrl_pkg.sv
// Purpose: Constants for the interrupt gating and low-power block
// Assumes: 32-bit AXI4-Lite register access, 50 MHz aclk
// Notes:   Byte offsets of own registers; field positions of the enable mask
package irq_ctrl_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] off_enable_mask = 8'h00;
    localparam logic [7:0] off_timer2_ctrl = 8'h04;
    localparam logic [7:0] off_power_ctrl  = 8'h08;
    localparam logic [7:0] off_status      = 8'h0c;
    localparam logic [7:0] off_ev_status   = 8'h10;
    localparam logic [7:0] off_ev_clear    = 8'h14;
    localparam logic [7:0] off_ev_enable   = 8'h18;

    // ------------------------------------------------------------
    // Enable mask fields
    // ------------------------------------------------------------
    localparam int bit_line0  = 0;
    localparam int bit_timer0 = 1;
    localparam int bit_line1  = 2;
    localparam int bit_timer1 = 3;
    localparam int bit_serial = 4;
    localparam int bit_timer2 = 5;
    localparam int bit_resvd  = 6;
    localparam int bit_global = 7;
    localparam logic [7:0] enable_mask_reset = 8'h00;
    localparam logic [7:0] enable_mask_wmask = 8'hbf;

    // ------------------------------------------------------------
    // Timer-2 control fields
    // ------------------------------------------------------------
    localparam int bit_t2_edge     = 6;
    localparam int bit_t2_overflow = 7;
    localparam int bit_t0_flag     = 0;
    localparam int bit_t1_flag     = 1;

    // ------------------------------------------------------------
    // Power control fields and source numbers
    // ------------------------------------------------------------
    localparam int bit_idle_req = 0;
    localparam int bit_pd_req   = 1;
    localparam int num_sources  = 6;
    localparam logic [1:0] reset_hold_cycles = 2'h2;

    // ------------------------------------------------------------
    // Vector addresses per source, priority order line0 first
    // ------------------------------------------------------------
    localparam logic [15:0] vec_line0  = 16'h0003;
    localparam logic [15:0] vec_timer0 = 16'h000b;
    localparam logic [15:0] vec_line1  = 16'h0013;
    localparam logic [15:0] vec_timer1 = 16'h001b;
    localparam logic [15:0] vec_serial = 16'h0023;
    localparam logic [15:0] vec_timer2 = 16'h002b;

    // ------------------------------------------------------------
    // Event bits
    // ------------------------------------------------------------
    localparam int ev_vector = 0;
    localparam int ev_wake   = 1;

    // ------------------------------------------------------------
    // Power state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        pm_run  = 3'b001,
        pm_idle = 3'b010,
        pm_down = 3'b100
    } power_mode_e;

endpackage

// ### src/irq_ctrl.sv
// Purpose: Interrupt request gating, vectoring and idle/power-down control
// Assumes: Machine-cycle phase strobes come from the core timing on aclk
// Notes:   Core handshakes vectors with vector_take at instruction boundaries
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps

// Notes on behaviour
// RULE1: Six sources: two outside lines, timers 0, 1, 2 and serial port.
// RULE2: Each source has an enable bit; 1 allows its request, 0 blocks it.
// RULE3: Global enable bit 7 at 0 blocks all; at 1 per-source bits apply.
// RULE4: Enables: timer2 b5, serial b4, timer1 b3, line1 b2, timer0 b1, line0 b0.
// RULE5: Software never writes one to reserved bit 6.
// RULE6: Timer-2 request is OR of overflow flag and edge flag.
// RULE7: Vectoring never clears timer-2 flags; software clears them itself.
// RULE8: Timer 0/1 flags set at state5 phase2, sampled next machine cycle.
// RULE9: Timer-2 overflow set at state2 phase2, sampled same machine cycle.
// RULE10: Idle stops the core; peripherals run; RAM and registers kept.
// RULE11: Idle ends on any enabled request or hardware reset.
// RULE12: Reset out of idle: two cycles RAM access blocked, port access not.
// RULE13: Software avoids port or external writes right after the idle request.
// RULE14: Power-down stops oscillator after requesting instruction; state kept.
// RULE15: Only hardware reset leaves power-down; registers reset, RAM kept. Code: a power-control write of the idle bit alone moves it to idle.
// RULE16: Idle holds strobes at 1, power-down at 0; port0 float external.
// RULE17: Pending requests served one at a time, fixed order, at boundaries.
module irq_ctrl (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Machine-cycle phase strobes
    input  wire logic        state2_phase2,
    input  wire logic        state5_phase2,
    // Request sources
    input  wire logic        outside_request_line0,
    input  wire logic        outside_request_line1,
    input  wire logic        timer0_overflow,
    input  wire logic        timer1_overflow,
    input  wire logic        timer2_overflow,
    input  wire logic        timer2_edge,
    input  wire logic        serial_request,
    // Core handshake
    input  wire logic        instr_boundary,
    input  wire logic        vector_take,
    input  wire logic        ext_program,
    output logic             vector_valid,
    output logic [15:0]      vector_addr,
    output logic [2:0]       vector_source,
    output logic             core_run,
    output logic             osc_run,
    output logic             ram_block,
    output logic             addr_latch_strobe,
    output logic             program_store_strobe,
    output logic             port0_float,
    output logic             port2_addr,
    output logic             irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic                      awready;
        logic                      wready;
        logic                      have_aw;
        logic                      have_w;
        logic [7:0]                awaddr;
        logic [31:0]               wdata;
        logic [3:0]                wstrb;
        logic                      bvalid;
        logic [1:0]                bresp;
        logic                      arready;
        logic                      rvalid;
        logic [31:0]               rdata;
        logic [1:0]                rresp;
        logic [7:0]                enable_mask;
        logic                      timer2_overflow_flag;
        logic                      timer2_edge_flag;
        logic                      timer0_overflow_flag;
        logic                      timer1_overflow_flag;
        logic [1:0]                line0_sync;
        logic [1:0]                line1_sync;
        logic                      line0_req;
        logic                      line1_req;
        logic                      timer0_seen;
        logic                      timer1_seen;
        irq_ctrl_pkg::power_mode_e mode;
        logic [1:0]                ram_hold;
        logic                      vector_valid;
        logic [15:0]               vector_addr;
        logic [2:0]                vector_source;
        logic [1:0]                ev_status;
        logic [1:0]                ev_enable;
        logic                      irq;
        logic                      core_run;
        logic                      osc_run;
        logic                      port0_float;
        logic                      port2_addr;
        logic                      ram_block;
    } state_s;

    state_s r;
    state_s next_r;

    // ------------------------------------------------------------
    // Combinational next state
    // ------------------------------------------------------------
    logic [5:0] pending;
    logic [5:0] gated;
    logic       any_gated;
    logic       w_fire;
    logic       rd_ok;
    logic       wr_ok;
    logic [31:0] wmask;
    logic [31:0] wval;
    logic [7:0] clr_ev;
    logic [1:0] set_ev;

    always_comb begin
        next_r = r;
        set_ev = 2'h0;
        clr_ev = 8'h00;
        rd_ok  = 1'b1;
        // Outside lines are active low, synchronised before use
        next_r.line0_sync = {r.line0_sync[0], ~outside_request_line0};
        next_r.line1_sync = {r.line1_sync[0], ~outside_request_line1};
        next_r.line0_req  = r.line0_sync[1];
        next_r.line1_req  = r.line1_sync[1];

        // Poll point of the following cycle
        if (state2_phase2) begin
            next_r.timer0_seen = r.timer0_overflow_flag; // see RULE8
            next_r.timer1_seen = r.timer1_overflow_flag; // see RULE8
        end

        // Request gating, fixed priority
        pending = {r.timer2_overflow_flag | r.timer2_edge_flag, // see RULE6
                   serial_request, r.timer1_seen, r.line1_req, r.timer0_seen, r.line0_req}; // see RULE1
        gated = pending & r.enable_mask[5:0] & {6{r.enable_mask[irq_ctrl_pkg::bit_global]}}; // see RULE2
        any_gated = |gated; // see RULE3

        // ------------------------------------------------------------
        // AXI4-Lite write channel
        // ------------------------------------------------------------
        next_r.awready = 1'b0;
        next_r.wready  = 1'b0;
        if (s_axi_awvalid && r.awready) begin
            next_r.have_aw = 1'b1;
            next_r.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && r.wready) begin
            next_r.have_w = 1'b1;
            next_r.wdata  = s_axi_wdata;
            next_r.wstrb  = s_axi_wstrb;
        end
        if (!r.have_aw && !r.awready && !r.bvalid && !(s_axi_awvalid && r.awready)) begin
            next_r.awready = s_axi_awvalid;
        end
        if (!r.have_w && !r.wready && !r.bvalid && !(s_axi_wvalid && r.wready)) begin
            next_r.wready = s_axi_wvalid;
        end
        w_fire = r.have_aw && r.have_w && !r.bvalid;
        wmask = {{8{r.wstrb[3]}}, {8{r.wstrb[2]}}, {8{r.wstrb[1]}}, {8{r.wstrb[0]}}};
        wval  = r.wdata & wmask;
        wr_ok = 1'b1;
        if (w_fire) begin
            next_r.have_aw = 1'b0;
            next_r.have_w  = 1'b0;
            next_r.bvalid  = 1'b1;
            case (r.awaddr)
                irq_ctrl_pkg::off_enable_mask: begin
                    if (wmask[0]) begin
                        // Reserved bit stays zero
                        next_r.enable_mask = r.wdata[7:0] & irq_ctrl_pkg::enable_mask_wmask; // see RULE4
                    end
                end
                irq_ctrl_pkg::off_timer2_ctrl: begin
                    // Software-only clear of timer-2, timer-0 and timer-1 flags
                    if (wmask[0] && !r.wdata[irq_ctrl_pkg::bit_t2_edge]) begin
                        next_r.timer2_edge_flag = 1'b0; // see RULE7
                    end
                    if (wmask[0] && !r.wdata[irq_ctrl_pkg::bit_t2_overflow]) begin
                        next_r.timer2_overflow_flag = 1'b0; // see RULE7
                    end
                    if (wmask[0] && !r.wdata[irq_ctrl_pkg::bit_t0_flag]) begin
                        next_r.timer0_overflow_flag = 1'b0;
                        next_r.timer0_seen = 1'b0;
                    end
                    if (wmask[0] && !r.wdata[irq_ctrl_pkg::bit_t1_flag]) begin
                        next_r.timer1_overflow_flag = 1'b0;
                        next_r.timer1_seen = 1'b0;
                    end
                end
                irq_ctrl_pkg::off_power_ctrl: begin
                    if (wval[irq_ctrl_pkg::bit_pd_req]) begin
                        next_r.mode = irq_ctrl_pkg::pm_down; // see RULE14
                    end else if (wval[irq_ctrl_pkg::bit_idle_req]) begin
                        next_r.mode = irq_ctrl_pkg::pm_idle; // see RULE10
                    end
                end
                irq_ctrl_pkg::off_ev_clear: clr_ev = wval[7:0];
                irq_ctrl_pkg::off_ev_enable: begin
                    if (wmask[0]) begin
                        next_r.ev_enable = r.wdata[1:0];
                    end
                end
                irq_ctrl_pkg::off_status,
                irq_ctrl_pkg::off_ev_status: wr_ok = 1'b1;
                default: wr_ok = 1'b0;
            endcase
            next_r.bresp = wr_ok ? 2'h0 : 2'h2;
        end
        if (r.bvalid && s_axi_bready) begin
            next_r.bvalid = 1'b0;
        end

        // Flags set after software clear so the set wins
        if (timer2_overflow && state2_phase2) begin
            next_r.timer2_overflow_flag = 1'b1; // see RULE9
        end
        if (timer2_edge) begin
            next_r.timer2_edge_flag = 1'b1;
        end
        if (timer0_overflow && state5_phase2) begin
            next_r.timer0_overflow_flag = 1'b1; // see RULE8
        end
        if (timer1_overflow && state5_phase2) begin
            next_r.timer1_overflow_flag = 1'b1; // see RULE8
        end

        // ------------------------------------------------------------
        // AXI4-Lite read channel
        // ------------------------------------------------------------
        next_r.arready = !r.arready && !r.rvalid && s_axi_arvalid;
        if (s_axi_arvalid && r.arready) begin
            rd_ok = 1'b1;
            case (s_axi_araddr)
                irq_ctrl_pkg::off_enable_mask: next_r.rdata = {24'h000000, r.enable_mask};
                irq_ctrl_pkg::off_timer2_ctrl: next_r.rdata = {24'h000000, r.timer2_overflow_flag,
                    r.timer2_edge_flag, 4'h0, r.timer1_overflow_flag, r.timer0_overflow_flag};
                irq_ctrl_pkg::off_power_ctrl:  next_r.rdata = 32'h00000000;
                irq_ctrl_pkg::off_status:      next_r.rdata = {21'h000000, r.mode, 2'h0, pending};
                irq_ctrl_pkg::off_ev_status:   next_r.rdata = {30'h00000000, r.ev_status};
                irq_ctrl_pkg::off_ev_clear:    next_r.rdata = 32'h00000000;
                irq_ctrl_pkg::off_ev_enable:   next_r.rdata = {30'h00000000, r.ev_enable};
                default: begin
                    next_r.rdata = 32'h00000000;
                    rd_ok = 1'b0;
                end
            endcase
            next_r.rvalid = 1'b1;
            next_r.rresp  = rd_ok ? 2'h0 : 2'h2;
        end else if (r.rvalid && s_axi_rready) begin
            next_r.rvalid = 1'b0;
        end

        // ------------------------------------------------------------
        // Vectoring and power modes
        // ------------------------------------------------------------
        if (r.vector_valid && vector_take) begin
            // Timer-2 flags deliberately left set
            next_r.vector_valid = 1'b0; // see RULE7
        end else if (!r.vector_valid && any_gated && instr_boundary && r.mode == irq_ctrl_pkg::pm_run) begin
            next_r.vector_valid = 1'b1; // see RULE17
            set_ev[irq_ctrl_pkg::ev_vector] = 1'b1;
            if (gated[0]) begin
                next_r.vector_addr = irq_ctrl_pkg::vec_line0;
                next_r.vector_source = 3'h0;
            end else if (gated[1]) begin
                next_r.vector_addr = irq_ctrl_pkg::vec_timer0;
                next_r.vector_source = 3'h1;
            end else if (gated[2]) begin
                next_r.vector_addr = irq_ctrl_pkg::vec_line1;
                next_r.vector_source = 3'h2;
            end else if (gated[3]) begin
                next_r.vector_addr = irq_ctrl_pkg::vec_timer1;
                next_r.vector_source = 3'h3;
            end else if (gated[4]) begin
                next_r.vector_addr = irq_ctrl_pkg::vec_serial;
                next_r.vector_source = 3'h4;
            end else begin
                next_r.vector_addr = irq_ctrl_pkg::vec_timer2;
                next_r.vector_source = 3'h5;
            end
        end
        case (r.mode)
            irq_ctrl_pkg::pm_run: ;
            irq_ctrl_pkg::pm_idle: begin
                if (any_gated) begin
                    next_r.mode = irq_ctrl_pkg::pm_run; // see RULE11
                    set_ev[irq_ctrl_pkg::ev_wake] = 1'b1;
                end
            end
            irq_ctrl_pkg::pm_down: ; // see RULE15
            default: next_r.mode = irq_ctrl_pkg::pm_run;
        endcase
        if (r.ram_hold != 2'h0) begin
            next_r.ram_hold = r.ram_hold - 2'h1;
        end
        next_r.core_run    = next_r.mode == irq_ctrl_pkg::pm_run; // see RULE10
        next_r.osc_run     = next_r.mode != irq_ctrl_pkg::pm_down; // see RULE14 RULE16
        next_r.port0_float = ext_program && next_r.mode != irq_ctrl_pkg::pm_run; // see RULE16
        next_r.port2_addr  = ext_program && next_r.mode == irq_ctrl_pkg::pm_idle; // see RULE16
        next_r.ram_block   = next_r.ram_hold != 2'h0; // see RULE12

        // Sticky events, set wins over clear
        next_r.ev_status = (r.ev_status & ~clr_ev[1:0]) | set_ev;
        next_r.irq = |(next_r.ev_status & r.ev_enable);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
            r.enable_mask <= irq_ctrl_pkg::enable_mask_reset; // see RULE15
            r.mode <= irq_ctrl_pkg::pm_run;
            r.core_run <= 1'b1;
            r.osc_run <= 1'b1;
            r.ram_block <= 1'b1;
            // RAM hold armed by idle and kept while reset stays low
            if (r.mode == irq_ctrl_pkg::pm_idle || r.ram_hold == irq_ctrl_pkg::reset_hold_cycles) begin
                r.ram_hold <= irq_ctrl_pkg::reset_hold_cycles; // see RULE12
            end else begin
                r.ram_hold <= 2'h0;
            end
        end else begin
            r <= next_r;
        end
    end

    assign s_axi_awready        = r.awready;
    assign s_axi_wready         = r.wready;
    assign s_axi_bvalid         = r.bvalid;
    assign s_axi_bresp          = r.bresp;
    assign s_axi_arready        = r.arready;
    assign s_axi_rvalid         = r.rvalid;
    assign s_axi_rdata          = r.rdata;
    assign s_axi_rresp          = r.rresp;
    assign vector_valid         = r.vector_valid;
    assign vector_addr          = r.vector_addr;
    assign vector_source        = r.vector_source;
    assign irq                  = r.irq;
    assign core_run             = r.core_run;
    assign osc_run              = r.osc_run;
    assign ram_block            = r.ram_block;
    assign addr_latch_strobe    = r.osc_run;
    assign program_store_strobe = r.osc_run;
    assign port0_float          = r.port0_float;
    assign port2_addr           = r.port2_addr;

endmodule

// ### dv/irq_ctrl_assertions.sv
// Purpose: Port-level checks of the interrupt gating block
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound into every irq_ctrl instance
`timescale 1ns/1ps
module irq_ctrl_assertions (
    input wire logic        aclk, aresetn, s_axi_bvalid, s_axi_bready, instr_boundary,
    input wire logic        vector_take, ext_program, vector_valid, core_run, osc_run,
    input wire logic        ram_block, addr_latch_strobe, program_store_strobe, port0_float,
    input wire logic [15:0] vector_addr,
    input wire logic [2:0]  vector_source
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    idle_strobe_a: assert property (!core_run && osc_run |-> addr_latch_strobe && program_store_strobe)
        else $error("strobes low in idle");
    down_strobe_a: assert property (!osc_run |-> !addr_latch_strobe && !program_store_strobe)
        else $error("strobes high in power-down");
    down_core_a: assert property (!osc_run |-> !core_run)
        else $error("core runs with oscillator stopped");
    down_stay_a: assert property (!osc_run |=> !osc_run)
        else $error("power-down left without reset");
    port0_float_a: assert property (!core_run && $past(core_run) == 1'b0 && $past(ext_program) |-> port0_float)
        else $error("port0 driven while halted");
    vector_hold_a: assert property (vector_valid && !vector_take |=> vector_valid && $stable(vector_addr))
        else $error("vector dropped before taken");
    vector_gate_a: assert property ($rose(vector_valid) |-> $past(instr_boundary))
        else $error("vector off a boundary");
    vector_addr_a: assert property (vector_valid |->
        vector_addr == irq_ctrl_pkg::vec_line0 + {10'h000, vector_source, 3'h0})
        else $error("vector address mismatch");
    resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    ram_release_a: assert property ($rose(aresetn) |-> ##[1:3] !ram_block)
        else $error("ram held blocked too long");
    cover property (vector_valid && vector_take);
    cover property (!core_run && osc_run);
    cover property (!osc_run);
endmodule
bind irq_ctrl irq_ctrl_assertions chk_u (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .instr_boundary,
    .vector_take, .ext_program, .vector_valid, .core_run, .osc_run, .ram_block, .addr_latch_strobe,
    .program_store_strobe, .port0_float, .vector_addr, .vector_source);

// ### dv/core_model.sv
// Purpose: Core side that flags an instruction boundary every other cycle and takes vectors
// Assumes: vector_valid stands until vector_take
// Notes:   slow delays each take by several cycles
`timescale 1ns/1ps
module core_model (
    input  wire logic aclk, aresetn, vector_valid, slow,
    output logic      instr_boundary, vector_take
);
    logic [2:0] cnt;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= 3'h0;
            instr_boundary <= 1'b0;
            vector_take <= 1'b0;
        end else begin
            instr_boundary <= !instr_boundary;
            cnt <= vector_valid ? cnt + 3'h1 : 3'h0;
            vector_take <= vector_valid && !vector_take && (!slow || cnt == 3'h5);
        end
    end
endmodule

// ### dv/testbench.sv
// Purpose: Self-checking bench for irq_ctrl
// Assumes: core_model answers vectors
// Notes:   Seeded random enables among fixed corner cases
`timescale 1ns/1ps
module testbench;
    logic        aclk = '0, aresetn = '0, awv = '0, wv = '0, bready = '0, arv = '0, rready = '0;
    logic        ext = '1, edg = '0, slow = '0;
    logic [7:0]  awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0;
    logic [5:0]  src = '0;
    logic [2:0]  ph = '0;
    wire         awready, wready, bvalid, arready, rvalid, vv, ib, vt, core_run, osc_run, als, pss, irq, p0f, p2a, rb;
    wire  [31:0] rdata;
    wire  [1:0]  rresp, bresp;
    wire  [2:0]  vs;
    int          error_cnt = 0, n_checks = 0, cyc = 0, seed = 77;
    irq_ctrl dut_u (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .state2_phase2(ph == 3'h1), .state5_phase2(ph == 3'h4),
        .outside_request_line0(!src[0]), .outside_request_line1(!src[2]), .timer0_overflow(src[1]),
        .timer1_overflow(src[3]), .timer2_overflow(src[5]), .timer2_edge(edg), .serial_request(src[4]),
        .instr_boundary(ib), .vector_take(vt), .ext_program(ext), .vector_valid(vv), .vector_addr(),
        .vector_source(vs), .core_run, .osc_run, .ram_block(rb), .addr_latch_strobe(als),
        .program_store_strobe(pss), .port0_float(p0f), .port2_addr(p2a), .irq);
    core_model core_u (.aclk, .aresetn, .vector_valid(vv), .slow, .instr_boundary(ib), .vector_take(vt));
    initial forever #10 aclk = ~aclk;
    always @(posedge aclk) begin
        ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] s, e);
        n_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a; wdata <= d; awv <= 1'b1; wv <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awv <= 1'b0;
            if (wready) wv <= 1'b0;
        end while ((awv && !awready) || (wv && !wready));
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        chk(bresp, 2'h0);
        bready <= 1'b0;
    endtask
    task automatic rdw(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] r);
        araddr <= a; arv <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arv <= 1'b0; rready <= 1'b1;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata & m, e);
        chk(rresp, r);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        logic g, seen;
        logic [2:0] vsrc;
        wt(3);
        aresetn <= 1'b1;
        wt(1);
        rdw(8'h00, 32'hff, 32'h0, 2'h0);
        wr(8'h00, 32'hbf);
        rdw(8'h00, '1, 32'hbf, 2'h0);
        rdw(8'h1c, '1, 32'h0, 2'h2);
        for (int i = 0; i < 6; i++) begin
            g = (i < 2) ? i[0] : 1'($random(seed));
            slow <= 1'($random(seed));
            ext <= 1'($random(seed));
            wr(8'h00, {24'h0, g, 1'b0, 6'h01 << i});
            if (i == 5 && slow) edg <= 1'b1;
            else src[i] <= 1'b1;
            seen = 1'b0;
            repeat (40) begin
                @(posedge aclk);
                edg <= 1'b0;
                if (vv === 1'b1 && !seen) begin seen = 1'b1; vsrc = vs; end
            end
            chk(seen, g);
            if (g) chk(vsrc, i);
            if (i % 2) rdw(8'h04, 32'hc3, (i == 5) ? (slow ? 32'h40 : 32'h80) : 32'h1 << (i / 2), 2'h0);
            src <= '0;
            wr(8'h04, 32'h0);
            wt(10);
            $display("source %0d done", i);
        end
        wr(8'h00, 32'h3f);
        src <= '1;
        wt(12);
        wr(8'h00, 32'hbf);
        do @(posedge aclk); while (vv !== 1'b1);
        chk(vs, 3'h0);
        src <= '0;
        wr(8'h04, 32'h0);
        $display("priority done");
        wr(8'h18, 32'h2);
        wr(8'h00, 32'h90);
        wr(8'h08, 32'h1);
        wt(4);
        chk({core_run, osc_run, als, pss, p0f, p2a}, {4'h7, ext, ext});
        src <= 6'h10;
        wt(6);
        chk({core_run, irq}, 2'h3);
        src <= '0;
        wr(8'h18, 32'h0);
        wt(4);
        chk(irq, 1'b0);
        wr(8'h18, 32'h2);
        wt(4);
        chk(irq, 1'b1);
        wr(8'h14, 32'h2);
        wt(4);
        chk(irq, 1'b0);
        wr(8'h08, 32'h1);
        wt(3);
        aresetn <= 1'b0;
        wt(3);
        aresetn <= 1'b1;
        wt(2);
        chk(rb, 1'b1);
        wt(2);
        $display("idle done");
        wr(8'h00, 32'h81);
        wr(8'h08, 32'h3);
        wt(4);
        chk({core_run, osc_run, als, pss, p0f, p2a}, {4'h0, ext, 1'b0});
        src <= 6'h01;
        wt(20);
        chk(osc_run, 1'b0);
        src <= '0;
        aresetn <= 1'b0;
        wt(3);
        aresetn <= 1'b1;
        wt(1);
        rdw(8'h00, 32'hff, 32'h0, 2'h0);
        $display("power-down done");
        test_done();
    end
endmodule
